//--- rtl/twop_core.sv
// Trace word output port: presents trace words to the probe interface block.
// Assumes stall and width/ratio codes come from logic on the core clock.
//
// Function
// - Ratio faster than 1:2: transfer every cycle
// - Ratio 1:2 or slower: transfer spans twice (code minus 3) core cycles
// - Width select sets shift amount and rate
// - Code 000 takes four bits, 100 all
// - Valid rises when new full-width word begins; stays low in narrow mode
// - Stall holds off next valid, valid stays
// - Stalled data and valid held until released
// - Stall sampled only before valid, full width
// - Each narrow transfer shifts data down by four bits
// - Full width: valid in first full-word cycle
// - Probe trigger synchronised twice, rising edge
// - Trigger strobe lasts exactly one transfer
`timescale 1ns/1ps
module twop_core #(
	parameter int unsigned DATA_W = twop_pkg::DATA_W  // Trace word width
) (
	input  wire logic                         clock,              // Core clock, 10 MHz
	input  wire logic                         rst_b,              // Asynchronous reset, active low
	input  wire logic [twop_pkg::RATIO_W-1:0] trace_clock_ratio,  // Trace clock ratio code
	input  wire logic [twop_pkg::WSEL_W-1:0]  trace_width_select, // Bits the probe takes
	input  wire logic                         trace_stall_in,     // Probe stall
	input  wire logic                         probe_trigger_in,   // Asynchronous probe trigger
	input  wire logic [DATA_W-1:0]            word_in,            // Next trace word from core
	input  wire logic                         word_in_valid,      // Core offers a word
	output logic                              word_in_ready,      // Word taken this cycle
	input  wire logic                         trigger_request,    // Core asks for a trigger strobe
	output logic [DATA_W-1:0]                 trace_word_out,     // Shifted trace data
	output logic                              trace_word_valid,   // New full word started
	output logic                              trigger_strobe_out, // Trigger to external probe
	output logic                              probe_trigger_seen  // Probe trigger edge, one cycle
);
	import twop_pkg::*;

	localparam int unsigned BEATS = DATA_W / NARROW_BITS;  // Narrow transfers per word
	localparam int unsigned BW    = $clog2(BEATS);         // Beat counter width
	localparam logic [BW-1:0] BEAT_LAST = BW'(BEATS - 1);  // Beats left after a load

	// All state of the port except the trigger synchroniser stages
	typedef struct packed {
		logic [DATA_W-1:0]  data;      // Presented word
		logic               valid;     // Word-valid flag
		logic [DIV_W-1:0]   div_cnt;   // Core cycles left in transfer cycle
		logic [BW-1:0]      beat_cnt;  // Narrow shifts left in word
		logic [WSEL_W-1:0]  width;     // Accepted width code
		logic [RATIO_W-1:0] ratio;     // Ratio in force
		logic               started;   // Codes captured after reset
		logic               hold;      // Word stalled
		logic               go;        // Stall released, load next
		logic               trig_pend; // Trigger waiting for a boundary
		logic               strobe;    // Trigger strobe
		logic               ptrig;     // Probe trigger edge
	} twop_core_state_t;

	twop_core_state_t st_q;  // Registered state
	twop_core_state_t st_d;  // Next state

	logic             ptrig_rise;  // Synchronised probe trigger edge
	logic             xfer_en;     // First core cycle of a transfer cycle
	logic             full;        // Full-width mode
	logic             slot;        // Room for a new word
	logic             stall_blk;   // Load blocked by stall
	logic             load;        // Word loaded this cycle
	logic             reconfig;    // Ratio changed or first capture
	logic [DIV_W-1:0] len;         // Transfer cycle length in core cycles

	// Transfer cycle length for a ratio code
	function automatic logic [DIV_W-1:0] xfer_len(input logic [RATIO_W-1:0] r);
		logic [RATIO_W-1:0] steps;
		steps = r - RATIO_SLOW_MIN + 3'h1;
		if (r < RATIO_SLOW_MIN) begin
			return 4'h1;
		end
		return {steps, 1'b0};
	endfunction

	// Probe trigger crossing
	twop_trig_sync u_trig_sync (
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in (probe_trigger_in),
		.rise_out (ptrig_rise)
	);

	// Decode of the current cycle
	always_comb begin
		len       = xfer_len(st_q.ratio);
		xfer_en   = (st_q.div_cnt == DIV_RST);
		full      = (st_q.width == WSEL_FULL);
		slot      = full | (st_q.beat_cnt == '0);
		reconfig  = !st_q.started || (trace_clock_ratio != st_q.ratio);
		// Stall is looked at only when a full word would load next
		stall_blk = full && xfer_en && !st_q.hold && !st_q.go && word_in_valid && trace_stall_in;
		load      = !reconfig && word_in_valid
		            && ((xfer_en && slot && !st_q.hold && !stall_blk) || st_q.go);
	end

	// Handshake to the core is combinational
	assign word_in_ready = load;

	// Next-state logic
	always_comb begin
		st_d         = st_q;
		st_d.ptrig   = ptrig_rise;
		st_d.started = 1'b1;
		st_d.ratio   = trace_clock_ratio;
		st_d.go      = 1'b0;
		if (reconfig) begin
			// New ratio: take a new width and restart transfers
			if (trace_width_select == WSEL_NARROW || trace_width_select == WSEL_FULL) begin
				st_d.width = trace_width_select;
			end
			st_d.div_cnt  = DIV_RST;
			st_d.beat_cnt = '0;
			st_d.valid    = 1'b0;
			st_d.hold     = 1'b0;
		end else begin
			// Divider paces transfer cycles
			st_d.div_cnt = xfer_en ? (len - 4'h1) : (st_q.div_cnt - 4'h1);
			if (load) begin
				// New word on all bits
				st_d.data     = word_in;
				st_d.valid    = full;
				st_d.beat_cnt = full ? '0 : BEAT_LAST;
				st_d.hold     = 1'b0;
			end else if (stall_blk) begin
				// Hold data and valid as they stand
				st_d.hold = 1'b1;
			end else if (st_q.hold) begin
				// Release one cycle after stall seen low; the go cycle then loads or drops valid
				st_d.hold = trace_stall_in;
				st_d.go   = !trace_stall_in;
			end else if (st_q.go) begin
				// Released but core had no word
				st_d.valid = 1'b0;
			end else if (xfer_en && !full) begin
				// Narrow mode: probe keeps reading low bits
				st_d.data  = st_q.data >> NARROW_BITS;
				st_d.valid = 1'b0;
				if (st_q.beat_cnt != '0) begin
					st_d.beat_cnt = st_q.beat_cnt - 1'b1;
				end
			end else begin
				// Valid marks only the first cycle of a word
				st_d.valid = 1'b0;
			end
		end
		// Trigger strobe spans one transfer cycle; a new request wins over the clear
		if (xfer_en) begin
			st_d.strobe = st_q.trig_pend;
		end
		st_d.trig_pend = trigger_request | (st_q.trig_pend & ~xfer_en);
	end

	// State register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_q         <= '0;
			st_q.width   <= WSEL_RST;
			st_q.ratio   <= RATIO_RST;
			st_q.div_cnt <= DIV_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flip-flops
	assign trace_word_out     = st_q.data;
	assign trace_word_valid   = st_q.valid;
	assign trigger_strobe_out = st_q.strobe;
	assign probe_trigger_seen = st_q.ptrig;

	// All checks below run on the core clock and rest during reset
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	// Fast ratios make every core cycle a transfer cycle
	property p_fast_xfer;
		st_q.started && st_q.ratio < RATIO_SLOW_MIN |-> xfer_en;
	endproperty
	a_fast_xfer: assert property (p_fast_xfer) else $error("fast ratio missed a transfer");

	// At 1:2 a transfer cycle spans two core cycles
	property p_slow_span;
		xfer_en && st_q.ratio == RATIO_SLOW_MIN && trace_clock_ratio == RATIO_SLOW_MIN
		##1 trace_clock_ratio == RATIO_SLOW_MIN |-> !xfer_en ##1 xfer_en;
	endproperty
	a_slow_span: assert property (p_slow_span) else $error("slow transfer span wrong");

	// Narrow mode moves the next nibble down at each boundary
	property p_narrow_shift;
		!reconfig && xfer_en && !full && !load |=> trace_word_out == ($past(trace_word_out) >> 4);
	endproperty
	a_narrow_shift: assert property (p_narrow_shift) else $error("narrow shift wrong");

	// A full word shows with valid in its first cycle
	property p_full_valid;
		load && full |=> trace_word_valid && trace_word_out == $past(word_in);
	endproperty
	a_full_valid: assert property (p_full_valid) else $error("full word not valid");

	// Valid never rises while the probe takes nibbles
	property p_narrow_novalid;
		st_q.width == WSEL_NARROW |=> !trace_word_valid;
	endproperty
	a_narrow_novalid: assert property (p_narrow_novalid) else $error("valid in narrow mode");

	// A stalled word keeps data and valid
	sequence s_blocked;
		stall_blk && trace_word_valid;
	endsequence
	property p_stall_hold;
		s_blocked |=> (trace_word_valid && $stable(trace_word_out)) [*2];
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("stalled word changed");

	// Stall seen low: the next offered word loads one cycle later
	sequence s_release;
		st_q.hold && !trace_stall_in && !reconfig;
	endsequence
	sequence s_reload;
		word_in_ready ##1 trace_word_valid;
	endsequence
	property p_release;
		s_release ##1 (word_in_valid && !reconfig) |-> s_reload;
	endproperty
	a_release: assert property (p_release) else $error("no reload after stall release");

	// Stall has no effect on narrow loads
	property p_narrow_nostall;
		!reconfig && !full && xfer_en && st_q.beat_cnt == '0 && word_in_valid |-> word_in_ready;
	endproperty
	a_narrow_nostall: assert property (p_narrow_nostall) else $error("stall used in narrow mode");

	// Strobe starts only on a boundary with a pending trigger
	property p_trig_start;
		$rose(trigger_strobe_out) |-> $past(xfer_en) && $past(st_q.trig_pend);
	endproperty
	a_trig_start: assert property (p_trig_start) else $error("strobe off boundary");

	// Strobe ends at the next boundary without a new request
	property p_trig_end;
		trigger_strobe_out && xfer_en && !st_q.trig_pend |=> !trigger_strobe_out;
	endproperty
	a_trig_end: assert property (p_trig_end) else $error("strobe longer than a transfer");

	// Nothing is taken while a new ratio and width are captured
	property p_reconfig_idle;
		reconfig |-> !word_in_ready;
	endproperty
	a_reconfig_idle: assert property (p_reconfig_idle) else $error("word taken during reconfiguration");

	// A held word refuses the next one
	property p_hold_wait;
		st_q.hold |-> !word_in_ready;
	endproperty
	a_hold_wait: assert property (p_hold_wait) else $error("word taken while stalled");

	// The release cycle takes an offered word
	property p_go_loads;
		st_q.go && word_in_valid && !reconfig |-> word_in_ready;
	endproperty
	a_go_loads: assert property (p_go_loads) else $error("release cycle did not load");

	// Narrow mode waits for all beats before the next word
	property p_beat_wait;
		!reconfig && !full && st_q.beat_cnt != '0 |-> !word_in_ready;
	endproperty
	a_beat_wait: assert property (p_beat_wait) else $error("word taken before last beat");

	// Only the two used width codes are ever in force
	property p_width_legal;
		st_q.width == WSEL_NARROW || st_q.width == WSEL_FULL;
	endproperty
	a_width_legal: assert property (p_width_legal) else $error("unused width code in force");

	// Stall cannot block a load outside full width
	property p_stall_full_only;
		!full |-> !stall_blk;
	endproperty
	a_stall_full_only: assert property (p_stall_full_only) else $error("stall blocked a narrow load");

	// Valid falls after one cycle unless held or reloaded
	property p_valid_drop;
		trace_word_valid && !st_q.hold && !load && !stall_blk |=> !trace_word_valid;
	endproperty
	a_valid_drop: assert property (p_valid_drop) else $error("valid stayed high");

	// Each synchronised edge reaches the seen output
	property p_seen_follows;
		ptrig_rise |=> probe_trigger_seen;
	endproperty
	a_seen_follows: assert property (p_seen_follows) else $error("probe trigger edge lost");

	// The seen output is a single-cycle pulse
	property p_seen_pulse;
		probe_trigger_seen |=> !probe_trigger_seen;
	endproperty
	a_seen_pulse: assert property (p_seen_pulse) else $error("probe trigger pulse too long");
endmodule // twop_core

//--- rtl/twop_pkg.sv
// Shared constants of the trace word output port.
// Assumes one core clock domain; no software-visible registers.
package twop_pkg;
	localparam int unsigned  DATA_W         = 64;     // Trace word width
	localparam int unsigned  WSEL_W         = 3;      // Width-select code width
	localparam int unsigned  RATIO_W        = 3;      // Clock ratio code width
	localparam int unsigned  DIV_W          = 4;      // Transfer divider width
	localparam int unsigned  NARROW_BITS    = 4;      // Bits taken per transfer, narrow mode
	localparam logic [WSEL_W-1:0]  WSEL_NARROW = 3'h0;  // Probe takes low four bits
	localparam logic [WSEL_W-1:0]  WSEL_FULL   = 3'h4;  // Probe takes all bits
	localparam logic [WSEL_W-1:0]  WSEL_RST    = 3'h4;  // Width after reset
	localparam logic [RATIO_W-1:0] RATIO_SLOW_MIN = 3'h4; // First code at 1:2 or slower
	localparam logic [RATIO_W-1:0] RATIO_RST      = 3'h0; // Ratio register after reset
	localparam logic [DIV_W-1:0]   DIV_RST        = 4'h0; // Divider after reset
endpackage : twop_pkg

//--- rtl/twop_trig_sync.sv
// Two-stage synchroniser with rising-edge detect for an asynchronous trigger.
// Assumes the input may toggle at any time relative to clock.
`timescale 1ns/1ps
module twop_trig_sync (
	input  wire logic clock,     // Core clock
	input  wire logic rst_b,     // Asynchronous reset, active low
	input  wire logic async_in,  // Asynchronous level from a pin
	output logic      rise_out   // One-cycle pulse on a rising edge
);
	import twop_pkg::*;

	// All state of the synchroniser
	typedef struct packed {
		logic meta;  // First stage, read only by the second
		logic sync;  // Second stage, safe to use
		logic last;  // Delayed copy for edge detect
	} twop_sync_state_t;

	twop_sync_state_t st_q;  // Registered state
	twop_sync_state_t st_d;  // Next state

	// Shift the level through the stages
	always_comb begin
		st_d      = st_q;
		st_d.meta = async_in;
		st_d.sync = st_q.meta;
		st_d.last = st_q.sync;
	end

	// State register
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Edge only after two stages
	assign rise_out = st_q.sync & ~st_q.last;

	property p_edge_seen;
		@(posedge clock) disable iff (!rst_b)
		(!async_in ##1 async_in [*3]) |-> ##[0:2] rise_out;
	endproperty
	a_edge_seen: assert property (p_edge_seen) else $error("trigger rise not detected");
endmodule // twop_trig_sync

//--- dv/twop_probe_model.sv
// Probe interface block model: stalls the core on request, drives the trigger pin.
// Assumes the core clock; wires only the low data bits it collects.
`timescale 1ns/1ps
module twop_probe_model (
	input  wire logic       clock,            // Core clock
	input  wire logic       stall_en,         // Bench asks for stalls
	input  wire logic       trig_en,          // Bench asks for a trigger
	input  wire logic       trace_word_valid, // Word valid from core
	input  wire logic [3:0] low_bits,         // Only low data bits wired
	output logic            trace_stall_in,   // Stall to core
	output logic            probe_trigger_in  // Trigger pin level
);
	logic [3:0] seen_q; // Last nibble collected

	// Stall the valid due next while a word is shown
	always_comb trace_stall_in = stall_en & trace_word_valid;
	// Pin moves off the clock grid, so the core sees it as asynchronous
	assign #37 probe_trigger_in = trig_en;
	// Collect only the low bits
	always_ff @(posedge clock) seen_q <= low_bits;
endmodule // twop_probe_model

//--- dv/tb_twop_core.sv
// Self-checking bench of the trace word output port with the probe model.
// Assumes twop_pkg, the design and the probe model are compiled first.
`timescale 1ns/1ps
module tb_twop_core;
	import twop_pkg::*;
	logic               clock = 1'b0;         // Core clock
	logic               rst_b = 1'b0;         // Reset, active low
	logic [RATIO_W-1:0] ratio = 3'h0;         // Ratio code
	logic [WSEL_W-1:0]  wsel = WSEL_FULL;     // Width code
	logic [63:0]        word_in = 64'h0;      // Offered word
	logic               word_in_valid = 1'b0; // Offer strobe
	logic               trigger_request = 1'b0;
	logic               stall_en = 1'b0;
	logic               trig_en = 1'b0;
	logic               stall, ptrig, ready, valid, strobe, seen;
	logic [63:0]        out, cur, prev_out;
	logic [63:0]        q[$];                 // Expected words
	logic               took_q = 1'b0;
	logic               hold_q = 1'b0;
	int                 n_errors = 0, n_checks = 0, cnt = 1000, span = 1, n_strobe = 0, n_seen = 0;

	always #50 clock = ~clock;

	twop_core u_dut (.clock(clock), .rst_b(rst_b), .trace_clock_ratio(ratio), .trace_width_select(wsel),
		.trace_stall_in(stall), .probe_trigger_in(ptrig), .word_in(word_in), .word_in_valid(word_in_valid),
		.word_in_ready(ready), .trigger_request(trigger_request), .trace_word_out(out),
		.trace_word_valid(valid), .trigger_strobe_out(strobe), .probe_trigger_seen(seen));
	twop_probe_model u_pib (.clock(clock), .stall_en(stall_en), .trig_en(trig_en), .trace_word_valid(valid),
		.low_bits(out[3:0]), .trace_stall_in(stall), .probe_trigger_in(ptrig));

	task automatic cmp_word(input logic [64:0] got, input logic [64:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_cnt(input int got, input int exp);
		cmp_word(65'(got), 65'(exp));
	endtask

	task automatic stop_test();
		$display("checks=%0d errors=%0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Watcher: compares each shown word with the oldest note
	always @(negedge clock) begin
		if (took_q && wsel == WSEL_FULL) cmp_word({valid, out}, {1'b1, q.pop_front()});
		if (took_q && wsel == WSEL_NARROW) begin
			cur = q.pop_front();
			cnt = 0;
		end
		// Narrow: one nibble per transfer, valid stays low
		if (wsel == WSEL_NARROW && cnt < 16 * span) begin
			cmp_word({valid, 60'h0, out[3:0]}, {1'b0, 60'h0, cur[4*(cnt/span)+:4]});
			cnt++;
		end
		if (hold_q) cmp_word({valid, out}, {1'b1, prev_out});
		hold_q = stall && valid && word_in_valid;
		took_q = word_in_valid && ready;
		prev_out = out;
		n_strobe += (strobe === 1'b1);
		n_seen += (seen === 1'b1);
	end

	// Offer one word and wait, bounded, until it is taken
	task automatic send(input logic [63:0] w);
		int k;
		word_in <= w;
		word_in_valid <= 1'b1;
		for (k = 0; k < 200; k++) begin
			@(negedge clock);
			if (ready === 1'b1) break;
		end
		if (k == 200) begin
			n_errors++;
			stop_test();
		end
		q.push_back(w);
		@(posedge clock);
	endtask

	task automatic burst(input int n);
		@(posedge clock);
		repeat (n) send({$urandom, $urandom});
		word_in_valid <= 1'b0;
		repeat (16 * span + 3) @(posedge clock);
	endtask

	// Width changes only together with the ratio, legal codes only
	task automatic set_mode(input logic [RATIO_W-1:0] r, input logic [WSEL_W-1:0] w);
		@(posedge clock);
		ratio <= r;
		wsel <= w;
		span = (r < 4) ? 1 : 2 * (r - 3);
		cnt = 1000; // No stale nibble checks across a mode change
		repeat (3) @(posedge clock);
	endtask

	task automatic trig();
		n_strobe = 0;
		n_seen = 0;
		@(posedge clock);
		trigger_request <= 1'b1;
		trig_en <= 1'b1;
		@(posedge clock);
		trigger_request <= 1'b0;
		repeat (40) @(posedge clock);
		cmp_cnt(n_strobe, span);
		cmp_cnt(n_seen, 1);
		trig_en <= 1'b0;
		repeat (10) @(posedge clock);
		cmp_cnt(n_seen, 1);
	endtask

	initial begin
		void'($urandom(32'ha5bbd7f9));
		repeat (2) @(posedge clock);
		@(negedge clock);
		cmp_word({valid, out}, 65'h0);
		@(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
		burst(8);
		$display("test full back-to-back done");
		fork
			burst(8);
			begin
				repeat (4) @(posedge clock);
				stall_en <= 1'b1;
				repeat (4) @(posedge clock);
				stall_en <= 1'b0;
			end
		join
		$display("test stall done");
		set_mode(3'h6, WSEL_FULL);
		burst(3);
		$display("test full slow done");
		set_mode(3'h1, WSEL_NARROW);
		burst(2);
		$display("test narrow fast done");
		set_mode(3'h5, WSEL_NARROW);
		burst(2);
		trig();
		$display("test narrow slow and trigger done");
		set_mode(3'h4, WSEL_FULL);
		burst(3);
		trig();
		$display("test full half-rate and trigger done");
		set_mode(3'h0, WSEL_FULL);
		trig();
		$display("test fast trigger done");
		stop_test();
	end
endmodule // tb_twop_core
